// ===== rtl/psi_hysteresis.sv
// Threshold comparator with hysteresis on the intake temperature.
// Assumes temperature is synchronous to clk; SET_C is above CLR_C.
`timescale 1ns/1ps
module psi_hysteresis
#(
	parameter logic [7:0] SET_C = 8'h4B,
	parameter logic [7:0] CLR_C = 8'h46
)
(
	input wire logic clk,
	input wire logic reset_n,
	psi_thermal_if.hys th
);
	import psi_pkg::*;

	// All state of the comparator
	typedef struct packed
	{
		logic flag;
	} psi_hys_state_t;

	psi_hys_state_t st; // Registered state
	psi_hys_state_t next_st; // Next state

	// Set at or above SET_C, clear at or below CLR_C, else hold;
	// the dead band keeps the flag from chattering near one point
	always_comb
	begin
		next_st = st;
		if (th.temp >= SET_C)
			next_st.flag = 1'b1;
		else if (th.temp <= CLR_C)
			next_st.flag = 1'b0;
	end

	// State register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign th.flag = st.flag;

	chk_hys_set: assert property (
		@(posedge clk) disable iff (!reset_n)
		(th.temp >= SET_C) |=> th.flag)
		else $error("hysteresis flag not set at threshold");
	chk_hys_clear: assert property (
		@(posedge clk) disable iff (!reset_n)
		(th.temp <= CLR_C) |=> !th.flag)
		else $error("hysteresis flag not cleared at recovery point");
	chk_hys_hold: assert property (
		@(posedge clk) disable iff (!reset_n)
		(th.temp > CLR_C && th.temp < SET_C) |=> $stable(th.flag))
		else $error("hysteresis flag moved inside the dead band");
endmodule

// ===== rtl/psi_pkg.sv
// Shared constants for the power module status indication block.
// Assumes a 100 MHz core clock and an 8-bit intake temperature in degC.
package psi_pkg;

	// Core clock rate
	localparam int CLK_MHZ = 100;

	// Blink half period, in ms; one hertz at fifty percent duty
	localparam real BLINK_HALF_MS = 500.0;
	localparam int BLINK_HALF_CYCLES = int'(BLINK_HALF_MS * 1000.0 * CLK_MHZ);
	localparam int BLINK_W = 26;

	// Least input-good pre-warning ahead of outputs-good, in ms
	localparam real EARLY_WARN_MS = 0.5;
	localparam int EARLY_WARN_CYCLES = int'(EARLY_WARN_MS * 1000.0 * CLK_MHZ);
	localparam int EARLY_W = 16;

	// Intake temperature thresholds, degC
	localparam int TEMP_W = 8;
	localparam logic [7:0] WARN_SET_C = 8'h4B;
	localparam logic [7:0] WARN_CLR_C = 8'h46;
	localparam logic [7:0] FAULT_SET_C = 8'h50;
	localparam logic [7:0] FAULT_CLR_C = 8'h4B;

	// Address strap decode: base | (level << 1)
	localparam int STRAP_W = 3;
	localparam logic [7:0] CTRL_ADDR_BASE = 8'hB0;
	localparam logic [7:0] EEPROM_ADDR_BASE = 8'hA0;

	// Open-drain data value while pulling low
	localparam logic OD_LOW = 1'b0;

	// Input-loss sequence, Gray coded along the usual path
	typedef enum logic [1:0]
	{
		PSI_LOSS_IDLE = 2'h0,
		PSI_LOSS_EARLY = 2'h1,
		PSI_LOSS_DOWN = 2'h3
	} psi_loss_t;

endpackage

// ===== rtl/psi_status_top.sv
// Status indication logic of the power module: LED, open-drain status
// lines, thermal warning and fault, address strap decode.
// Assumes all inputs are synchronous to clk; all but main_enable_n and addr_strap come from analog monitors.
`timescale 1ns/1ps
module psi_status_top
#(
	parameter int BLINK_CYCLES = psi_pkg::BLINK_HALF_CYCLES,
	parameter int EARLY_CYCLES = psi_pkg::EARLY_WARN_CYCLES
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic input_present,
	input wire logic input_in_limits,
	input wire logic standby_on,
	input wire logic main_output_on,
	input wire logic outputs_valid,
	input wire logic main_below_limit,
	input wire logic main_oc_warn,
	input wire logic main_uv_warn,
	input wire logic main_ov_warn,
	input wire logic fan_fault,
	input wire logic standby_oc_fault,
	input wire logic main_oc_fault,
	input wire logic main_ov_fault,
	input wire logic module_warning,
	input wire logic [psi_pkg::TEMP_W-1:0] intake_temp,
	input wire logic [psi_pkg::STRAP_W-1:0] addr_strap,
	input wire logic main_enable_n,
	output logic main_enable,
	output logic thermal_warning,
	output logic thermal_fault,
	output logic latched_fault,
	output logic led_green,
	output logic led_amber,
	output logic input_good_o,
	output logic input_good_oe,
	output logic outputs_good_flag_o,
	output logic outputs_good_flag_oe,
	output logic alert_n_o,
	output logic alert_n_oe,
	output logic [7:0] ctrl_addr,
	output logic [7:0] eeprom_addr
);
	import psi_pkg::*;

	// Counter end values at the counters' own widths
	localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_CYCLES - 1);
	localparam logic [EARLY_W-1:0] EARLY_LAST = EARLY_W'(EARLY_CYCLES - 1);

	// All state of the block apart from the two thermal comparator flags
	typedef struct packed
	{
		psi_loss_t loss; // Input-loss sequence
		logic [EARLY_W-1:0] early_cnt; // Pre-warning timer
		logic [BLINK_W-1:0] blink_cnt; // Blink half-period timer
		logic blink_on; // Blink phase
		logic enable_n_prev; // Last main-enable level
		logic latched; // Latched main output fault
		logic main_on; // Main output enable to power stage
		logic strap_done; // Strap has been captured
		logic input_good; // Input-good line level
		logic outputs_good; // Outputs-good line level
		logic alert_act; // Alert pulled low
		logic green; // Green element lit
		logic amber; // Amber element lit
		logic [7:0] ctrl_addr; // Controller target address
		logic [7:0] eeprom_addr; // EEPROM target address
	} psi_state_t;

	psi_state_t st; // Registered state
	psi_state_t next_st; // Next state

	logic input_ok; // Input present and within limits
	logic module_off; // No input and no standby
	logic amber_solid; // Any cause for solid amber
	logic alert_cause; // Any warning or fault
	logic enable_toggle; // Main-enable changed level
	logic fault_event; // Latching main output fault seen

	psi_thermal_if warn_if (); // Warning comparator link
	psi_thermal_if fault_if (); // Fault comparator link

	assign warn_if.temp = intake_temp;
	assign fault_if.temp = intake_temp;

	// Warning: set 75C, clear 70C
	psi_hysteresis #(.SET_C(WARN_SET_C), .CLR_C(WARN_CLR_C)) u_warn
	(
		.clk(clk),
		.reset_n(reset_n),
		.th(warn_if)
	);

	// Fault: set 80C, clear 75C, restarts on its own
	psi_hysteresis #(.SET_C(FAULT_SET_C), .CLR_C(FAULT_CLR_C)) u_fault
	(
		.clk(clk),
		.reset_n(reset_n),
		.th(fault_if)
	);

	// Condition decode, all from current inputs and state
	always_comb
	begin
		input_ok = input_present && input_in_limits;
		module_off = !input_present && !standby_on;
		amber_solid = main_oc_warn || main_uv_warn ||
			main_ov_warn || fan_fault || standby_oc_fault ||
			main_oc_fault || main_ov_fault || warn_if.flag ||
			fault_if.flag || st.latched;
		alert_cause = amber_solid || module_warning;
		enable_toggle = (main_enable_n != st.enable_n_prev);
		fault_event = main_oc_fault || main_ov_fault;
	end

	// Next state
	always_comb
	begin
		next_st = st;
		// Free-running blink timebase shared by both colours
		if (st.blink_cnt >= BLINK_LAST)
		begin
			next_st.blink_cnt = '0;
			next_st.blink_on = !st.blink_on;
		end
		else
			next_st.blink_cnt = st.blink_cnt + 1'b1;

		// Latched faults: a new fault wins over a toggle in one cycle
		next_st.enable_n_prev = main_enable_n;
		if (fault_event)
			next_st.latched = 1'b1;
		else if (enable_toggle)
			next_st.latched = 1'b0;

		// Main on only when host asks and nothing blocks it
		next_st.main_on = !main_enable_n && !fault_if.flag &&
			!st.latched;

		// Input loss: hold outputs-good up for the pre-warning time
		case (st.loss)
			PSI_LOSS_IDLE:
			begin
				if (!input_ok)
				begin
					next_st.loss = PSI_LOSS_EARLY;
					next_st.early_cnt = '0;
				end
			end
			PSI_LOSS_EARLY:
			begin
				if (input_ok)
					next_st.loss = PSI_LOSS_IDLE;
				else if (st.early_cnt >= EARLY_LAST)
					next_st.loss = PSI_LOSS_DOWN;
				else
					next_st.early_cnt = st.early_cnt + 1'b1;
			end
			PSI_LOSS_DOWN:
			begin
				if (input_ok)
					next_st.loss = PSI_LOSS_IDLE;
			end
			default:
			begin
				next_st.loss = PSI_LOSS_IDLE;
			end
		endcase

		// Status line levels
		next_st.input_good = input_ok;
		next_st.outputs_good = outputs_valid &&
			!main_below_limit &&
			(next_st.loss != PSI_LOSS_DOWN);
		next_st.alert_act = alert_cause;

		// LED priority: off, solid amber, blink amber, green
		if (module_off)
		begin
			next_st.green = 1'b0;
			next_st.amber = 1'b0;
		end
		else if (amber_solid)
		begin
			next_st.green = 1'b0;
			next_st.amber = 1'b1;
		end
		else if (module_warning)
		begin
			next_st.green = 1'b0;
			next_st.amber = st.blink_on;
		end
		else if (standby_on && main_output_on)
		begin
			next_st.green = 1'b1;
			next_st.amber = 1'b0;
		end
		else if (standby_on && input_ok)
		begin
			next_st.green = st.blink_on;
			next_st.amber = 1'b0;
		end
		else
		begin
			next_st.green = 1'b0;
			next_st.amber = 1'b0;
		end

		// Strap is read once after reset; a moving strap is ignored
		if (!st.strap_done)
		begin
			next_st.strap_done = 1'b1;
			next_st.ctrl_addr = CTRL_ADDR_BASE | {4'h0, addr_strap, 1'b0};
			next_st.eeprom_addr = EEPROM_ADDR_BASE | {4'h0, addr_strap, 1'b0};
		end
	end

	// State register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			st <= '0;
		else
			st <= next_st;
	end

	// Outputs; open-drain lines only ever pull low
	assign main_enable = st.main_on;
	assign thermal_warning = warn_if.flag;
	assign thermal_fault = fault_if.flag;
	assign latched_fault = st.latched;
	assign led_green = st.green;
	assign led_amber = st.amber;
	assign input_good_o = OD_LOW;
	assign input_good_oe = !st.input_good;
	assign outputs_good_flag_o = OD_LOW;
	assign outputs_good_flag_oe = !st.outputs_good;
	assign alert_n_o = OD_LOW;
	assign alert_n_oe = st.alert_act;
	assign ctrl_addr = st.ctrl_addr;
	assign eeprom_addr = st.eeprom_addr;

	chk_led_dark_off: assert property (
		@(posedge clk) disable iff (!reset_n)
		module_off |=> (!led_green && !led_amber))
		else $error("LED lit while module fully off");
	chk_green_solid_on: assert property (
		@(posedge clk) disable iff (!reset_n)
		(!module_off && !alert_cause && standby_on && main_output_on)
		|=> led_green)
		else $error("green not solid with both rails on");
	chk_green_blink: assert property (
		@(posedge clk) disable iff (!reset_n)
		(!module_off && !alert_cause && standby_on && !main_output_on &&
		input_ok) |=> (led_green == $past(st.blink_on)))
		else $error("green not following blink phase");
	chk_amber_over_green: assert property (
		@(posedge clk) disable iff (!reset_n)
		(!module_off && amber_solid) |=> (led_amber && !led_green))
		else $error("amber not solid or green not dark");
	chk_amber_blink: assert property (
		@(posedge clk) disable iff (!reset_n)
		(!module_off && !amber_solid && module_warning)
		|=> (led_amber == $past(st.blink_on)) && !led_green)
		else $error("amber not blinking on module warning");
	chk_addr_pair: assert property (
		@(posedge clk) disable iff (!reset_n)
		st.strap_done |-> (ctrl_addr[0] == 1'b0 &&
		ctrl_addr[3:0] == eeprom_addr[3:0] &&
		ctrl_addr[7:4] == CTRL_ADDR_BASE[7:4] &&
		eeprom_addr[7:4] == EEPROM_ADDR_BASE[7:4]))
		else $error("target addresses not decoded as a pair");
	chk_input_good_lvl: assert property (
		@(posedge clk) disable iff (!reset_n)
		1'b1 |=> (input_good_oe == !$past(input_ok)))
		else $error("input-good line not tracking input");
	chk_early_warn: assert property (
		@(posedge clk) disable iff (!reset_n)
		(st.loss == PSI_LOSS_EARLY && next_st.loss == PSI_LOSS_DOWN)
		|-> (st.early_cnt == EARLY_LAST))
		else $error("outputs-good dropped before pre-warning time");
	chk_outputs_good: assert property (
		@(posedge clk) disable iff (!reset_n)
		(!outputs_valid || main_below_limit) |=> outputs_good_flag_oe)
		else $error("outputs-good not low on failed output");
	chk_alert_follow: assert property (
		@(posedge clk) disable iff (!reset_n)
		1'b1 |=> (alert_n_oe == $past(alert_cause)))
		else $error("alert not following its cause");
	chk_fault_clear: assert property (
		@(posedge clk) disable iff (!reset_n)
		(enable_toggle && !fault_event) |=> !latched_fault)
		else $error("latched fault not cleared by enable toggle");
	chk_shutdown: assert property (
		@(posedge clk) disable iff (!reset_n)
		fault_if.flag |=> !main_enable)
		else $error("main output on during thermal fault");
endmodule

// ===== rtl/psi_thermal_if.sv
// Carrier between the status top and one thermal hysteresis comparator.
// Assumes the top drives the temperature and reads back the flag.
`timescale 1ns/1ps
interface psi_thermal_if;
	logic [psi_pkg::TEMP_W-1:0] temp; // Intake temperature, degC
	logic flag; // Threshold condition held with hysteresis

	modport src
	(
		output temp,
		input flag
	);
	modport hys
	(
		input temp,
		output flag
	);
endinterface

// ===== tb/psi_host_model.sv
// Host side model: pull-ups on the open-drain status lines, main enable.
// Assumes the bench changes want_on away from the rising clock edge.
`timescale 1ns/1ps
module psi_host_model
(
	input wire logic want_on,
	input wire logic ig_o,
	input wire logic ig_oe,
	input wire logic og_o,
	input wire logic og_oe,
	input wire logic al_o,
	input wire logic al_oe,
	output logic main_enable_n,
	output logic input_good,
	output logic outputs_good,
	output logic alert_n
);
	// Released lines float up through the pull-up, never to X
	assign input_good = ig_oe ? ig_o : 1'b1;
	assign outputs_good = og_oe ? og_o : 1'b1;
	assign alert_n = al_oe ? al_o : 1'b1;
	// Pulled low to run the main output, left high to stop it
	assign main_enable_n = !want_on;
endmodule

// ===== tb/tb.sv
// Self-checking bench of the status block with a host model.
// Assumes short blink and early warning counts set below.
`timescale 1ns/1ps
module tb;
	import psi_pkg::*;
	localparam int BLK = 8; // Blink half period, cycles
	localparam int ERL = 10; // Early warning span, cycles
	logic clk = 0;
	logic reset_n = 0;
	logic [13:0] st = '0; // Status inputs, present first
	logic [7:0] temp = 8'h19; // Intake temperature
	logic [2:0] strap = '0;
	logic want_on = 1;
	logic men, men_n, lg, la, ig_o, ig_oe, og_o, og_oe, al_o, al_oe;
	logic tw, tf, lf; // Thermal flags and latched fault of the block
	logic ig, og, al;
	logic [7:0] ca, ea;
	logic [31:0] rs = 32'h2EF1; // Fixed seed keeps runs repeatable
	int miscompares = 0;
	int checks = 0;
	int gc, ac, n;
	localparam logic [7:0] TT [9] = '{8'h4A, 8'h4B, 8'h47, 8'h46, 8'h4F,
		8'h50, 8'h4C, 8'h4B, 8'h3C};
	localparam logic [0:8] TW = 9'b011011110; // Warning per step
	localparam logic [0:8] TF = 9'b000001100; // Fault per step
	localparam logic [13:0] CV [5] = '{14'h0000, 14'h3800, 14'h3E00,
		14'h3E01, 14'h0010};

	// Free-running clock, 100 MHz
	initial
	begin
		forever #5 clk = !clk;
	end

	psi_status_top #(.BLINK_CYCLES(BLK), .EARLY_CYCLES(ERL)) i_psi_status_top
	(
		.clk(clk), .reset_n(reset_n), .input_present(st[13]),
		.input_in_limits(st[12]), .standby_on(st[11]),
		.main_output_on(st[10]), .outputs_valid(st[9]),
		.main_below_limit(st[8]), .main_oc_warn(st[7]),
		.main_uv_warn(st[6]), .main_ov_warn(st[5]), .fan_fault(st[4]),
		.standby_oc_fault(st[3]), .main_oc_fault(st[2]),
		.main_ov_fault(st[1]), .module_warning(st[0]),
		.intake_temp(temp), .addr_strap(strap), .main_enable_n(men_n),
		.main_enable(men), .thermal_warning(tw), .thermal_fault(tf),
		.latched_fault(lf), .led_green(lg), .led_amber(la),
		.input_good_o(ig_o), .input_good_oe(ig_oe),
		.outputs_good_flag_o(og_o), .outputs_good_flag_oe(og_oe),
		.alert_n_o(al_o), .alert_n_oe(al_oe), .ctrl_addr(ca),
		.eeprom_addr(ea)
	);

	psi_host_model i_psi_host_model
	(
		.want_on(want_on), .ig_o(ig_o), .ig_oe(ig_oe), .og_o(og_o),
		.og_oe(og_oe), .al_o(al_o), .al_oe(al_oe),
		.main_enable_n(men_n), .input_good(ig), .outputs_good(og),
		.alert_n(al)
	);

	// Xorshift step for stimulus
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction

	// Random status vector; latching fault bits stay clear, and the
	// warning bits are thinned so that clean vectors occur as well
	function automatic logic [13:0] rnd_vec();
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] c;
		a = rnd();
		b = rnd();
		c = rnd();
		return {a[13:8], a[7:0] & b[7:0] & c[7:0] & 8'hF9};
	endfunction

	// Lit cycles of green and amber over one full blink period
	function automatic logic [9:0] exp_led(logic [13:0] s);
		if (!s[13] && !s[11])
			return '0;
		if (|s[7:1])
			return 10'h010;
		if (s[0])
			return 10'h008;
		if (s[11] && s[10])
			return 10'h200;
		if (s[11] && s[13] && s[12])
			return 10'h100;
		return '0;
	endfunction

	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Counts, verdict, end of run
	task automatic print_verdict();
		$display("miscompares %0d checks %0d", miscompares, checks);
		if (miscompares == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Apply one status vector and judge LEDs and status lines
	task automatic apply(input logic [13:0] v);
		logic [9:0] e;
		@(negedge clk) st = v;
		repeat (3) @(negedge clk);
		gc = 0;
		ac = 0;
		e = exp_led(v);
		repeat (2 * BLK)
		begin
			@(negedge clk);
			gc += (lg === 1'b1);
			ac += (la === 1'b1);
		end
		chk(16'(gc), e[9:5]);
		chk(16'(ac), e[4:0]);
		chk(ig, v[13] & v[12]);
		chk(og, v[9] & !v[8] & v[13] & v[12]);
		chk(al, !(|v[7:0]));
		chk(men, 1'b1);
	endtask

	// Main sequence
	initial
	begin
		// Every strap level, each behind a fresh reset
		for (int l = 0; l < 8; l++)
		begin
			@(negedge clk) reset_n = 0;
			strap = l[2:0];
			repeat (16) @(negedge clk);
			reset_n = 1;
			repeat (2) @(negedge clk);
			strap = ~strap; // Late strap change must be ignored
			repeat (2) @(negedge clk);
			chk(ca, 8'hB0 + 8'(l * 2));
			chk(ea, 8'hA0 + 8'(l * 2));
		end
		// Corner vectors, then random ones without latching faults
		foreach (CV[i])
			apply(CV[i]);
		repeat (40)
			apply(rnd_vec());
		// Thermal hysteresis walk with all rails good
		@(negedge clk) st = 14'h3E00;
		foreach (TT[i])
		begin
			@(negedge clk) temp = TT[i];
			repeat (4) @(negedge clk);
			chk(tw, TW[i]);
			chk(tf, TF[i]);
			chk(al, !TW[i]);
			chk(la, TW[i]);
			chk(men, !TF[i]);
		end
		// Input loss: early warning ahead of outputs-good
		repeat (4) @(negedge clk);
		st[13] = 0;
		@(negedge clk);
		chk(ig, 1'b0);
		n = 0;
		while (og === 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		chk(n >= ERL && n <= ERL + 2, 1'b1);
		st = 14'h3F00; // Main under its lower limit
		repeat (3) @(negedge clk);
		chk(og, 1'b0);
		// Latching faults, cleared by toggling main enable
		for (int k = 1; k < 3; k++)
		begin
			st = 14'h3E00 | (14'h1 << k);
			@(negedge clk) st = 14'h3E00;
			repeat (3) @(negedge clk);
			chk(men, 1'b0);
			chk(lf, 1'b1);
			chk(al, 1'b0);
			want_on = 0;
			@(negedge clk) want_on = 1;
			repeat (3) @(negedge clk);
			chk(men, 1'b1);
			chk(lf, 1'b0);
			chk(al, 1'b1);
		end
		print_verdict();
	end

	// Hang guard, well beyond the expected run
	initial
	begin
		#500000;
		miscompares++;
		print_verdict();
	end
endmodule
